// ---- odst_defines.vh ----
// Constants for the orientation detection and status block.
// Assumes a byte-wide register port and one sample strobe per output sample.
`ifndef ODST_DEFINES_VH
`define ODST_DEFINES_VH
`define ODST_ADDR_STATUS  8'h10
`define ODST_ADDR_CONFIG  8'h11
`define ODST_ADDR_COUNT   8'h12
`define ODST_ST_FLAG      7
`define ODST_ST_LOCK      6
`define ODST_ST_CODE_HI   2
`define ODST_ST_CODE_LO   1
`define ODST_ST_BF        0
`define ODST_CF_MODE      7
`define ODST_CF_EN        6
`define ODST_CFG_RESET    8'h80
`define ODST_CNT_RESET    8'h00
`define ODST_CFG_MASK     8'hc0
// 1.25 g in 12-bit counts at 2 g full scale (1024 counts per g)
`define ODST_G_LIMIT      12'h500
// Axis word width, axis count and the one used for negation
`define ODST_AXIS_W       12
`define ODST_N_AXES       3
`define ODST_AXIS_ONE     12'h001
`define ODST_ZERO8        8'h00
`define ODST_ONE8         8'h01
`endif

// ---- odst_debounce.v ----
// Debounce counter for a pending orientation candidate.
// Assumes sample strobes and a candidate-differs level on core_clk.
`timescale 1ns/1ns
`default_nettype none
`include "odst_defines.vh"
module odst_debounce
(
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       sample,
  input  wire       pending,
  input  wire       clear,
  input  wire       mode_clear,
  input  wire [7:0] limit,
  output wire       done
);
  reg [7:0] cnt_r;
  reg [7:0] cnt_nxt;

  // Counting, decrement or clear when the condition lapses
  always @*
  begin
    cnt_nxt = cnt_r;
    if (clear)
      cnt_nxt = `ODST_ZERO8;
    else if (sample)
    begin
      if (pending)
      begin
        if (cnt_r < limit)
          cnt_nxt = cnt_r + `ODST_ONE8;
      end
      else if (mode_clear)
        cnt_nxt = `ODST_ZERO8;
      else if (cnt_r != `ODST_ZERO8)
        cnt_nxt = cnt_r - `ODST_ONE8;
    end
  end

  always @(posedge core_clk)
  begin
    if (!nrst)
      cnt_r <= `ODST_ZERO8;
    else if (done)
      cnt_r <= `ODST_ZERO8; // Next candidate starts from zero
    else
      cnt_r <= cnt_nxt;
  end

  // Commit once the programmed count is reached
  assign done = sample & pending & (cnt_nxt >= limit);
endmodule
`default_nettype wire

// ---- odst_orient.v ----
// Orientation detection unit: classifier, debounce, status and config regs.
// Assumes axis samples arrive with a one-cycle sample strobe on core_clk,
// and register accesses are single-cycle strobes from the register port.
`timescale 1ns/1ns
`default_nettype none
`include "odst_defines.vh"
module odst_orient
(
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        sample,
  input  wire [11:0] axis_x,
  input  wire [11:0] axis_y,
  input  wire [11:0] axis_z,
  input  wire [11:0] lock_z_limit,
  input  wire        active,
  input  wire        sleep_mode,
  input  wire        irq_enable,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output wire        orient_irq_source
);
  // Register state
  reg        orient_change_flag_r;
  reg        tilt_lockout_r;
  reg  [1:0] orient_code_r;
  reg        back_front_r;
  reg  [7:0] orientation_config_r;
  reg  [7:0] orientation_debounce_count_r;
  reg        first_r;
  reg        active_d_r;
  reg        sleep_d_r;
  reg  [1:0] cand_code;
  reg        cand_bf;
  reg        cand_lock;
  reg  [7:0] rdata_nxt;
  // Decodes and control
  wire       orient_enable;
  wire       debounce_mode;
  wire       status_rd;
  wire       over_g;
  wire       run;
  wire       differs;
  wire       commit;
  wire       mode_change;
  wire       went_active;
  wire       cfg_wr;
  wire       cnt_wr;
  wire       sample_ok;
  // Axis words, their magnitudes and per-axis over-range flags
  wire [35:0] axis_all;
  wire [35:0] axis_mag;
  wire [2:0]  axis_over;
  wire [11:0] ax;
  wire [11:0] ay;
  wire [11:0] az;

  assign debounce_mode = orientation_config_r[`ODST_CF_MODE];
  assign orient_enable = orientation_config_r[`ODST_CF_EN];
  assign status_rd = reg_rd & (reg_addr == `ODST_ADDR_STATUS);
  // Register write decodes
  assign cfg_wr = reg_wr & (reg_addr == `ODST_ADDR_CONFIG);
  assign cnt_wr = reg_wr & (reg_addr == `ODST_ADDR_COUNT);
  // Standby to active edge; it also restarts the debounce
  assign went_active = active & ~active_d_r;
  assign mode_change = (sleep_mode != sleep_d_r) | went_active;

  // Per-axis magnitude and 1.25 g over-range check
  assign axis_all = {axis_z, axis_y, axis_x};
  genvar gi;
  generate
    for (gi = 0; gi < `ODST_N_AXES; gi = gi + 1)
    begin : g_axis
      wire [`ODST_AXIS_W-1:0] raw;
      assign raw = axis_all[gi*`ODST_AXIS_W +: `ODST_AXIS_W];
      assign axis_mag[gi*`ODST_AXIS_W +: `ODST_AXIS_W] =
        raw[`ODST_AXIS_W-1] ? (~raw + `ODST_AXIS_ONE) : raw;
      assign axis_over[gi] =
        axis_mag[gi*`ODST_AXIS_W +: `ODST_AXIS_W] > `ODST_G_LIMIT;
    end
  endgenerate

  assign ax = axis_mag[`ODST_AXIS_W-1:0];
  assign ay = axis_mag[2*`ODST_AXIS_W-1:`ODST_AXIS_W];
  assign az = axis_mag[3*`ODST_AXIS_W-1:2*`ODST_AXIS_W];

  // Candidate classification from the larger in-plane magnitude
  always @*
  begin
    if (ay >= ax)
      cand_code = axis_y[11] ? 2'h1 : 2'h0;
    else
      cand_code = axis_x[11] ? 2'h3 : 2'h2;
    cand_bf = axis_z[11];
    cand_lock = az > lock_z_limit;
  end

  // Detection runs only when enabled, active and no axis is above 1.25 g
  assign over_g = |axis_over;
  assign run = active & orient_enable & ~over_g;
  assign sample_ok = sample & run;
  assign differs = first_r | (cand_code != orient_code_r) |
                   (cand_bf != back_front_r) |
                   (cand_lock != tilt_lockout_r);

  // Debounce a differing candidate before it commits
  odst_debounce u_deb
  (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .sample     (sample_ok),
    .pending    (differs),
    .clear      (mode_change),
    .mode_clear (debounce_mode),
    .limit      (orientation_debounce_count_r),
    .done       (commit)
  );

  // Wake/sleep and standby edge tracking
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      active_d_r <= 1'b0;
      sleep_d_r <= 1'b0;
    end
    else
    begin
      active_d_r <= active;
      sleep_d_r <= sleep_mode;
    end
  end

  // First-result marker, raised again on each standby to active edge
  always @(posedge core_clk)
  begin
    if (!nrst)
      first_r <= 1'b1;
    else if (went_active)
      first_r <= 1'b1;
    else if (commit)
      first_r <= 1'b0;
  end

  // Change flag; a commit in the cycle of a clearing read wins
  always @(posedge core_clk)
  begin
    if (!nrst)
      orient_change_flag_r <= 1'b0;
    else if (commit)
      orient_change_flag_r <= 1'b1;
    else if (status_rd)
      orient_change_flag_r <= 1'b0;
  end

  // Status fields follow each commit, flag set or not
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      tilt_lockout_r <= 1'b0;
      orient_code_r <= 2'h0;
      back_front_r <= 1'b0;
    end
    else if (commit)
    begin
      tilt_lockout_r <= cand_lock;
      orient_code_r <= cand_code;
      back_front_r <= cand_bf;
    end
  end

  // Configuration and debounce count registers
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      orientation_config_r <= `ODST_CFG_RESET;
      orientation_debounce_count_r <= `ODST_CNT_RESET;
    end
    else if (reg_wr)
    begin
      if (cfg_wr)
        orientation_config_r <= reg_wdata & `ODST_CFG_MASK;
      if (cnt_wr)
        orientation_debounce_count_r <= reg_wdata;
    end
  end

  // Read data mux
  always @*
  begin
    rdata_nxt = `ODST_ZERO8;
    case (reg_addr)
      `ODST_ADDR_STATUS:
      begin
        rdata_nxt[`ODST_ST_FLAG] = orient_change_flag_r;
        rdata_nxt[`ODST_ST_LOCK] = tilt_lockout_r;
        rdata_nxt[`ODST_ST_CODE_HI:`ODST_ST_CODE_LO] = orient_code_r;
        rdata_nxt[`ODST_ST_BF] = back_front_r;
      end
      `ODST_ADDR_CONFIG: rdata_nxt = orientation_config_r;
      `ODST_ADDR_COUNT:  rdata_nxt = orientation_debounce_count_r;
      default:           rdata_nxt = `ODST_ZERO8;
    endcase
  end

  // Read data captured on each read strobe, held between reads
  always @(posedge core_clk)
  begin
    if (!nrst)
      reg_rdata <= `ODST_ZERO8;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
  end

  // Interrupt source follows flag gated by enable
  assign orient_irq_source = orient_change_flag_r & irq_enable;
endmodule
`default_nettype wire

// ---- odst_orient_properties.sv ----
// Port checker for odst_orient, bound to every instance.
// Assumes one clock core_clk and sync active-low nrst.
`timescale 1ns/1ns
`default_nettype none
module odst_chk
(
  input wire       core_clk,
  input wire       nrst,
  input wire       sample,
  input wire       active,
  input wire       irq_enable,
  input wire [7:0] reg_addr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       orient_irq_source
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // Status read strobe and irq alias
  wire st_rd = reg_rd && reg_addr == 8'h10;
  wire irq   = orient_irq_source;
  irq_gated_a: assert property (irq |-> irq_enable)
    else $error("irq high while disabled");
  rst_zero_a: assert property (disable iff (1'b0)
    !nrst |=> reg_rdata == 8'h00 && !irq) else $error("reset value");
  irq_cause_a: assert property ($rose(irq) && !$rose(irq_enable)
    |-> $past(sample) && $past(active)) else $error("irq without sample");
  rd_clear_a: assert property (st_rd && !sample |=> !irq)
    else $error("irq kept after read");
  irq_keep_a: assert property (irq && !st_rd |=> irq || !irq_enable)
    else $error("irq dropped early");
  rd_flag_a: assert property (st_rd && irq |=> reg_rdata[7])
    else $error("flag not read");
  st_zero_a: assert property (st_rd |=> reg_rdata[5:3] == 3'h0)
    else $error("status bits 5:3 set");
  cfg_zero_a: assert property (reg_rd && reg_addr == 8'h11
    |=> reg_rdata[5:0] == 6'h00) else $error("config bits 5:0 set");
  // Main scenarios reached
  c_irq_c: cover property ($rose(irq));
  c_clr_c: cover property (st_rd && irq);
  c_cfg_c: cover property (reg_rd && reg_addr == 8'h11);
endmodule
bind odst_orient odst_chk u_odst_chk
(
  .core_clk(core_clk), .nrst(nrst), .sample(sample), .active(active),
  .irq_enable(irq_enable), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .orient_irq_source(orient_irq_source)
);
`default_nettype wire

// ---- odst_orient_tb.sv ----
// Self-checking bench for odst_orient.
// Assumes the checker file is compiled beside it.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: %s", $time, m); end end
module odst_orient_tb;
  logic        core_clk = 0, nrst = 0, sample = 0, active = 1;
  logic        sleep_mode = 0, irq_enable = 1, wr = 0, rd = 0;
  logic [11:0] ax = 0, ay = 0, az = 0;
  logic [7:0]  addr = 0, wd = 0;
  wire  [7:0]  rdata;
  wire         irq;
  int          n_tests = 0, n_fail = 0;
  // Rows: x, y, z, then expected status
  logic [43:0] rows [6] = '{44'h000_400_100_80, 44'h000_c00_100_82,
    44'h400_000_100_84, 44'hc00_000_100_86, 44'hc00_000_f00_87,
    44'hc00_000_400_c6};
  odst_orient u_odst_orient
  (
    .core_clk(core_clk), .nrst(nrst), .sample(sample), .axis_x(ax),
    .axis_y(ay), .axis_z(az), .lock_z_limit(12'h300), .active(active),
    .sleep_mode(sleep_mode), .irq_enable(irq_enable), .reg_addr(addr),
    .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdata),
    .orient_irq_source(irq)
  );
  always #5 core_clk = ~core_clk;
  // One register cycle; a read compares with d
  task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {wr, rd, addr, wd} = {w, !w, a, d};
    @(negedge core_clk);
    {wr, rd} = 2'b00;
    if (!w) `CHK(rdata, d, "register read")
  endtask
  // Axis values, then n one-cycle sample pulses
  task automatic smp(input logic [35:0] v, input int n);
    {ax, ay, az} = v;
    repeat (2 * n) @(negedge core_clk) sample = !sample;
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog, several times the expected run
  initial
  begin
    #20000;
    n_fail++;
    complete_run;
  end
  initial
  begin
    repeat (4) @(negedge core_clk);
    nrst = 1;
    rw(0, 8'h10, 8'h00);
    rw(0, 8'h11, 8'h80);
    rw(0, 8'h12, 8'h00);
    smp(36'h400_000_100, 1);
    rw(0, 8'h10, 8'h00);
    rw(1, 8'h11, 8'hff);
    rw(0, 8'h11, 8'hc0);
    $display("reset and enable test done");
    foreach (rows[i])
    begin
      smp(rows[i][43:8], 1);
      `CHK(irq, 1'b1, "irq after change")
      rw(0, 8'h10, rows[i][7:0]);
      `CHK(irq, 1'b0, "irq after read")
    end
    $display("orientation table test done");
    smp(36'h600_000_100, 1);
    rw(0, 8'h10, 8'h46);
    smp(36'h400_000_100, 1);
    smp(36'h000_400_100, 1);
    irq_enable = 0;
    @(negedge core_clk);
    `CHK(irq, 1'b0, "irq while disabled")
    irq_enable = 1;
    rw(0, 8'h10, 8'h80);
    rw(1, 8'h12, 8'h04);
    rw(0, 8'h12, 8'h04);
    for (int m = 0; m < 2; m++)
    begin
      rw(1, 8'h11, m ? 8'hc0 : 8'h40);
      smp(m ? 36'h000_400_100 : 36'h000_c00_100, 3);
      smp(m ? 36'h000_c00_100 : 36'h000_400_100, 1);
      smp(m ? 36'h000_400_100 : 36'h000_c00_100, 3);
      rw(0, 8'h10, m ? 8'h02 : 8'h82);
    end
    $display("debounce test done");
    sleep_mode = 1;
    smp(36'h000_400_100, 3);
    rw(0, 8'h10, 8'h02);
    smp(36'h000_400_100, 1);
    rw(0, 8'h10, 8'h80);
    rw(1, 8'h12, 8'h00);
    active = 0;
    @(negedge core_clk) active = 1;
    smp(36'h000_400_100, 1);
    `CHK(irq, 1'b1, "irq after going active")
    rw(0, 8'h10, 8'h80);
    $display("wake and standby test done");
    nrst = 0;
    repeat (2) @(negedge core_clk);
    nrst = 1;
    rw(0, 8'h10, 8'h00);
    rw(0, 8'h11, 8'h80);
    $display("second reset test done");
    complete_run;
  end
endmodule
`default_nettype wire
